//--- rtl/smr_defines.vh
// Register map, field positions, reset values and FIFO depth for the synchronous master receiver
`ifndef SMR_DEFINES_VH
`define SMR_DEFINES_VH
`define SMR_ADDR_W 3
`define SMR_ADDR_CTRL 3'h0
`define SMR_ADDR_DATA 3'h1
`define SMR_ADDR_BAUD 3'h2
`define SMR_ADDR_MODE 3'h3
`define SMR_ADDR_IRQ_STATUS 3'h4
`define SMR_ADDR_IRQ_ENABLE 3'h5
`define SMR_ADDR_IRQ_CLEAR 3'h6
`define SMR_BIT_SERIAL_PORT_ON 7
`define SMR_BIT_NINE_BIT_SELECT 6
`define SMR_BIT_SINGLE_RX 5
`define SMR_BIT_CONT_RX 4
`define SMR_BIT_OVERRUN 1
`define SMR_BIT_NINTH 0
`define SMR_BIT_SYNC_MODE 0
`define SMR_BIT_CLOCK_ORIGIN 1
`define SMR_IRQ_RX 0
`define SMR_IRQ_OVR 1
`define SMR_CTRL_RESET 8'h00
`define SMR_BAUD_RESET 8'h00
`define SMR_FIFO_DEPTH 2
`endif

//--- rtl/smr_sync_master_rx.v
// Synchronous master serial receiver with two-deep receive FIFO and register port
//
// Overview of operation
// - Reception starts only once single or continuous receive enable is set in sync mode.
// - Each data bit is sampled at the falling edge of the shift clock.
// - Single-receive enable receives exactly one word then stops.
// - Continuous-receive enable receives words back to back until cleared.
// - With both enables set, continuous reception wins over single.
// - After the last bit, the shift register moves into the FIFO if room.
// - Receive flag rises on FIFO load, read-only, clears when FIFO read empty.
// - Receive flag reaches the interrupt only while its enable is set.
// - FIFO holds two words while a third may be shifting in.
// - Full FIFO at a word's last bit sets overrun and drops the word.
// - While overrun is set, no word moves into the FIFO.
// - Overrun clears only when software clears continuous receive enable.
// - Ninth bit is queued with its byte; each FIFO read updates it.
`timescale 1ns/1ps
`include "smr_defines.vh"
module smr_sync_master_rx (
  input wire ref_clk_i,
  input wire rst_n_i,
  input wire [`SMR_ADDR_W-1:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [7:0] rdata_o,
  input wire data_pin_i,
  output reg shift_clk_o,
  output reg shift_clk_oe_o,
  output wire irq_o
);
  localparam ST_IDLE = 2'd0;
  localparam ST_HIGH = 2'd1;
  localparam ST_LOW = 2'd2;
  reg [1:0] state_reg;
  reg [7:0] ctrl_reg;
  reg [7:0] baud_divisor_reg;
  reg [1:0] mode_reg;
  reg [1:0] irq_status_reg;
  reg [1:0] irq_enable_reg;
  reg overrun_error_reg;
  reg receive_flag_reg;
  reg [7:0] baud_cnt_reg;
  reg [3:0] bit_cnt_reg;
  reg [8:0] receive_shift_register_reg;
  reg [8:0] fifo_mem_reg [0:`SMR_FIFO_DEPTH-1];
  reg rd_ptr_reg;
  reg wr_ptr_reg;
  reg [1:0] fifo_cnt_reg;
  reg data_meta_reg;
  reg data_sync_reg;
  wire port_on;
  wire nine_bit;
  wire single_en;
  wire cont_en;
  wire sync_master;
  wire rx_active;
  wire baud_tick;
  wire last_bit;
  wire word_done;
  wire fifo_full;
  wire fifo_empty;
  wire fifo_push;
  wire fifo_pop;
  wire overrun_set;
  wire cont_clear_wr;
  wire [8:0] head_word;
  wire [3:0] word_len;
  reg [8:0] shift_next;
  assign port_on = ctrl_reg[`SMR_BIT_SERIAL_PORT_ON];
  assign nine_bit = ctrl_reg[`SMR_BIT_NINE_BIT_SELECT];
  assign single_en = ctrl_reg[`SMR_BIT_SINGLE_RX];
  assign cont_en = ctrl_reg[`SMR_BIT_CONT_RX];
  assign sync_master = port_on & mode_reg[`SMR_BIT_SYNC_MODE] & mode_reg[`SMR_BIT_CLOCK_ORIGIN];
  assign rx_active = sync_master & (single_en | cont_en);
  assign baud_tick = (baud_cnt_reg == baud_divisor_reg);
  assign word_len = nine_bit ? 4'd9 : 4'd8;
  assign last_bit = (bit_cnt_reg == word_len - 4'd1);
  assign word_done = (state_reg == ST_LOW) & baud_tick & last_bit;
  assign fifo_full = (fifo_cnt_reg == 2'd2);
  assign fifo_empty = (fifo_cnt_reg == 2'd0);
  assign fifo_push = word_done & ~fifo_full & ~overrun_error_reg;
  assign overrun_set = word_done & fifo_full & ~overrun_error_reg;
  assign fifo_pop = rd_i & (addr_i == `SMR_ADDR_DATA) & ~fifo_empty;
  assign cont_clear_wr = wr_i & (addr_i == `SMR_ADDR_CTRL) & ~wdata_i[`SMR_BIT_CONT_RX];
  assign head_word = fifo_mem_reg[rd_ptr_reg];
  assign irq_o = |(irq_status_reg & irq_enable_reg);
  // Falling edge of shift clock: place the new bit by position
  always @* begin
    shift_next = receive_shift_register_reg;
    shift_next[bit_cnt_reg] = data_sync_reg;
  end
  // Data pin synchroniser
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      data_meta_reg <= 1'b0;
      data_sync_reg <= 1'b0;
    end else begin
      data_meta_reg <= data_pin_i;
      data_sync_reg <= data_meta_reg;
    end
  end
  // Shift clock generator and bit sampler
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= ST_IDLE;
      baud_cnt_reg <= 8'h00;
      bit_cnt_reg <= 4'h0;
      receive_shift_register_reg <= 9'h000;
      shift_clk_o <= 1'b0;
      shift_clk_oe_o <= 1'b0;
    end else begin
      shift_clk_oe_o <= sync_master;
      case (state_reg)
        ST_IDLE: begin
          shift_clk_o <= 1'b0;
          baud_cnt_reg <= 8'h00;
          bit_cnt_reg <= 4'h0;
          if (rx_active) begin
            state_reg <= ST_HIGH;
            shift_clk_o <= 1'b1;
            receive_shift_register_reg <= 9'h000;
          end
        end
        ST_HIGH: begin
          if (!rx_active) begin
            state_reg <= ST_IDLE;
            shift_clk_o <= 1'b0;
          end else if (baud_tick) begin
            baud_cnt_reg <= 8'h00;
            state_reg <= ST_LOW;
            shift_clk_o <= 1'b0;
            receive_shift_register_reg <= shift_next;
          end else begin
            baud_cnt_reg <= baud_cnt_reg + 8'h01;
          end
        end
        default: begin
          if (!rx_active) begin
            state_reg <= ST_IDLE;
          end else if (baud_tick) begin
            baud_cnt_reg <= 8'h00;
            if (last_bit) begin
              bit_cnt_reg <= 4'h0;
              receive_shift_register_reg <= 9'h000;
              if (cont_en) begin
                state_reg <= ST_HIGH;
                shift_clk_o <= 1'b1;
              end else begin
                state_reg <= ST_IDLE;
              end
            end else begin
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
              state_reg <= ST_HIGH;
              shift_clk_o <= 1'b1;
            end
          end else begin
            baud_cnt_reg <= baud_cnt_reg + 8'h01;
          end
        end
      endcase
    end
  end
  // Receive FIFO, two entries
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fifo_mem_reg[0] <= 9'h000;
      fifo_mem_reg[1] <= 9'h000;
      rd_ptr_reg <= 1'b0;
      wr_ptr_reg <= 1'b0;
      fifo_cnt_reg <= 2'd0;
    end else begin
      if (fifo_push) begin
        fifo_mem_reg[wr_ptr_reg] <= nine_bit ? receive_shift_register_reg : {1'b0, receive_shift_register_reg[7:0]};
        wr_ptr_reg <= ~wr_ptr_reg;
      end
      if (fifo_pop) begin
        rd_ptr_reg <= ~rd_ptr_reg;
      end
      if (fifo_push & ~fifo_pop) begin
        fifo_cnt_reg <= fifo_cnt_reg + 2'd1;
      end else if (fifo_pop & ~fifo_push) begin
        fifo_cnt_reg <= fifo_cnt_reg - 2'd1;
      end
    end
  end
  // Control, flags and interrupt registers
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_reg <= `SMR_CTRL_RESET;
      baud_divisor_reg <= `SMR_BAUD_RESET;
      mode_reg <= 2'b00;
      irq_enable_reg <= 2'b00;
      irq_status_reg <= 2'b00;
      overrun_error_reg <= 1'b0;
      receive_flag_reg <= 1'b0;
    end else begin
      if (wr_i) begin
        if (addr_i == `SMR_ADDR_CTRL) begin
          ctrl_reg <= wdata_i;
        end else if (addr_i == `SMR_ADDR_BAUD) begin
          baud_divisor_reg <= wdata_i;
        end else if (addr_i == `SMR_ADDR_MODE) begin
          mode_reg <= wdata_i[1:0];
        end else if (addr_i == `SMR_ADDR_IRQ_ENABLE) begin
          irq_enable_reg <= wdata_i[1:0];
        end
      end
      if (word_done & ~cont_en & ~(wr_i & (addr_i == `SMR_ADDR_CTRL))) begin
        ctrl_reg[`SMR_BIT_SINGLE_RX] <= 1'b0;
      end
      if (overrun_set) begin
        overrun_error_reg <= 1'b1;
      end else if (cont_clear_wr) begin
        overrun_error_reg <= 1'b0;
      end
      if (fifo_push) begin
        receive_flag_reg <= 1'b1;
      end else if (fifo_pop & (fifo_cnt_reg == 2'd1)) begin
        receive_flag_reg <= 1'b0;
      end
      irq_status_reg[`SMR_IRQ_RX] <= receive_flag_reg | fifo_push |
        (irq_status_reg[`SMR_IRQ_RX] & ~(wr_i & (addr_i == `SMR_ADDR_IRQ_CLEAR) & wdata_i[`SMR_IRQ_RX]));
      irq_status_reg[`SMR_IRQ_OVR] <= overrun_set |
        (irq_status_reg[`SMR_IRQ_OVR] & ~(wr_i & (addr_i == `SMR_ADDR_IRQ_CLEAR) & wdata_i[`SMR_IRQ_OVR]));
    end
  end
  // Read port, data one cycle after the strobe
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      if (addr_i == `SMR_ADDR_CTRL) begin
        rdata_o <= {ctrl_reg[7:4], 2'b00, overrun_error_reg, head_word[8]};
      end else if (addr_i == `SMR_ADDR_DATA) begin
        rdata_o <= head_word[7:0];
      end else if (addr_i == `SMR_ADDR_BAUD) begin
        rdata_o <= baud_divisor_reg;
      end else if (addr_i == `SMR_ADDR_MODE) begin
        rdata_o <= {6'h00, mode_reg};
      end else if (addr_i == `SMR_ADDR_IRQ_STATUS) begin
        rdata_o <= {5'h00, receive_flag_reg, irq_status_reg};
      end else if (addr_i == `SMR_ADDR_IRQ_ENABLE) begin
        rdata_o <= {6'h00, irq_enable_reg};
      end else begin
        rdata_o <= 8'h00;
      end
    end else begin
      rdata_o <= 8'h00;
    end
  end
endmodule // smr_sync_master_rx

//--- testbench/smr_rx_asserts.sv
// Port checker for the synchronous master receiver
`timescale 1ns/1ps
`include "smr_defines.vh"
module smr_rx_asserts (
  input wire ref_clk_i,
  input wire rst_n_i,
  input wire [`SMR_ADDR_W-1:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  input wire [7:0] rdata_o,
  input wire shift_clk_o,
  input wire shift_clk_oe_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  reg [7:0] baud_reg;
  reg [1:0] en_reg;
  reg lvl_reg;
  reg [9:0] run_reg;
  wire [9:0] half = {2'b00, baud_reg} + 10'h001;
  // Shadow divisor and enables, and length of the current clock level
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      {baud_reg, en_reg, lvl_reg, run_reg} <= 21'h00_0000;
    end else begin
      if (wr_i && addr_i == `SMR_ADDR_BAUD) baud_reg <= wdata_i;
      if (wr_i && addr_i == `SMR_ADDR_CTRL) en_reg <= wdata_i[5:4];
      lvl_reg <= shift_clk_o;
      run_reg <= (shift_clk_o != lvl_reg) ? 10'h001 : run_reg + {9'h000, ~&run_reg};
    end
  end
  property p_idle; !rd_i |=> rdata_o == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("read data not idle");
  property p_unmapped; rd_i && addr_i == 3'h7 |=> rdata_o == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_gap; rd_i && addr_i == `SMR_ADDR_CTRL |=> rdata_o[3:2] == 2'b00; endproperty
  a_gap: assert property (p_gap) else $error("unused control bits set");
  property p_stat; rd_i && addr_i == `SMR_ADDR_IRQ_STATUS |=> rdata_o[7:3] == 5'h00; endproperty
  a_stat: assert property (p_stat) else $error("unused status bits set");
  property p_high; $fell(shift_clk_o) && !$past(wr_i) && !$past(wr_i, 2) |-> run_reg == half; endproperty
  a_high: assert property (p_high) else $error("high phase length wrong");
  property p_low; $rose(shift_clk_o) |-> run_reg >= half; endproperty
  a_low: assert property (p_low) else $error("low phase too short");
  property p_start; $rose(shift_clk_o) |-> $past(en_reg) != 2'b00; endproperty
  a_start: assert property (p_start) else $error("clock without enable");
  property p_off; !shift_clk_oe_o |-> !shift_clk_o; endproperty
  a_off: assert property (p_off) else $error("clock while not master");
endmodule // smr_rx_asserts
bind smr_sync_master_rx smr_rx_asserts u_chk (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .shift_clk_o(shift_clk_o),
  .shift_clk_oe_o(shift_clk_oe_o));

//--- testbench/smr_slave_model.sv
// Serial slave model driving eight- or nine-bit words onto the data pin
`timescale 1ns/1ps
module smr_slave_model (
  input wire shift_clk_i,
  input wire nine_i,
  input wire [8:0] word_i,
  output reg data_o = 1'b0,
  output reg [3:0] idx_o = 4'h0
);
  reg [8:0] sh_reg = 9'h000;
  // Bit set up on the rise, held over the sampling fall, LSB first
  always @(posedge shift_clk_i) begin
    sh_reg <= (idx_o == 4'h0 ? word_i : sh_reg) >> 1;
    data_o <= idx_o == 4'h0 ? word_i[0] : sh_reg[0];
    idx_o <= idx_o == (nine_i ? 4'h8 : 4'h7) ? 4'h0 : idx_o + 4'h1;
  end
  // Between words the line is not held: show the inverse of the last bit
  always @(negedge shift_clk_i) if (idx_o == 4'h0) data_o <= ~data_o;
endmodule // smr_slave_model

//--- testbench/smr_sync_master_rx_tb.sv
// Self-checking bench for the synchronous master receiver
`timescale 1ns/1ps
`include "smr_defines.vh"
module smr_sync_master_rx_tb;
  reg ref_clk_i = 1'b0, rst_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, rd_q = 1'b0;
  reg [2:0] addr_i = 3'h0;
  reg [7:0] wdata_i = 8'h00;
  reg [8:0] word = 9'h000;
  reg nine = 1'b1;
  reg [8:0] w [0:2];
  reg [15:0] e;
  reg [15:0] exp_q[$];
  reg [31:0] seed = 32'h0000_dea2;
  wire [7:0] rdata_o;
  wire [3:0] idx;
  wire pin, sck, irq_o;
  integer n_fail = 0, checks_done = 0, cyc = 0, k;
  always #4 ref_clk_i = ~ref_clk_i;
  smr_sync_master_rx dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .data_pin_i(pin), .shift_clk_o(sck), .shift_clk_oe_o(),
    .irq_o(irq_o));
  smr_slave_model slave (.shift_clk_i(sck), .nine_i(nine), .word_i(word), .data_o(pin), .idx_o(idx));
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task cmp8(input [7:0] got, input [7:0] x);
    begin
      checks_done = checks_done + 1;
      if (got !== x) begin
        n_fail = n_fail + 1;
        $display("unexpected at %0t: got %h expected %h", $time, got, x);
      end
    end
  endtask
  // One register cycle; a read also notes its masked expectation
  task bus(input we, input [2:0] a, input [7:0] d, input [7:0] m);
    begin
      @(posedge ref_clk_i);
      {addr_i, wdata_i} <= {a, d};
      {wr_i, rd_i} <= {we, !we};
      if (!we) exp_q.push_back({m, d & m});
      @(posedge ref_clk_i);
      {wr_i, rd_i} <= 2'b00;
    end
  endtask
  task tally_and_finish;
    begin
      if (n_fail == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask
  always @(posedge ref_clk_i) begin
    rd_q <= rd_i;
    cyc <= cyc + 1;
    if (rd_q) begin
      e = exp_q.pop_front();
      cmp8(rdata_o & e[15:8], e[7:0]);
    end
    if (cyc == 6000) begin
      n_fail = n_fail + 1;
      tally_and_finish;
    end
  end
  initial begin
    for (k = 0; k < 3; k = k + 1) begin
      seed = lfsr(lfsr(seed));
      w[k] = seed[8:0] | {k[0], 8'h00};
    end
    repeat (12) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    bus(0, `SMR_ADDR_CTRL, `SMR_CTRL_RESET, 8'hff);
    bus(0, 3'h7, 8'h00, 8'hff);
    bus(1, `SMR_ADDR_BAUD, 8'h07, 8'h00);
    bus(1, `SMR_ADDR_MODE, 8'h03, 8'h00);
    bus(1, `SMR_ADDR_CTRL, 8'hc0, 8'h00);
    bus(1, `SMR_ADDR_IRQ_ENABLE, 8'h01, 8'h00);
    word <= w[0];
    bus(1, `SMR_ADDR_CTRL, 8'he0, 8'h00);
    while (irq_o !== 1'b1) @(posedge ref_clk_i);
    bus(0, `SMR_ADDR_CTRL, {7'h60, w[0][8]}, 8'hff);
    bus(0, `SMR_ADDR_DATA, w[0][7:0], 8'hff);
    bus(0, `SMR_ADDR_IRQ_STATUS, 8'h01, 8'hff);
    bus(1, `SMR_ADDR_IRQ_ENABLE, 8'h00, 8'h00);
    @(negedge ref_clk_i);
    cmp8({7'h00, irq_o}, 8'h00);
    bus(1, `SMR_ADDR_IRQ_CLEAR, 8'h01, 8'h00);
    bus(1, `SMR_ADDR_IRQ_ENABLE, 8'h01, 8'h00);
    @(negedge ref_clk_i);
    cmp8({7'h00, irq_o}, 8'h00);
    repeat (200) @(posedge ref_clk_i);
    bus(0, `SMR_ADDR_IRQ_STATUS, 8'h00, 8'hff);
    nine <= 1'b0;
    word <= w[2];
    bus(1, `SMR_ADDR_CTRL, 8'ha0, 8'h00);
    while (irq_o !== 1'b1) @(posedge ref_clk_i);
    bus(0, `SMR_ADDR_CTRL, 8'h80, 8'hff);
    bus(0, `SMR_ADDR_DATA, w[2][7:0], 8'hff);
    nine <= 1'b1;
    word <= w[0];
    bus(1, `SMR_ADDR_CTRL, 8'hf0, 8'h00);
    for (k = 1; k < 5; k = k + 1) begin
      while (idx !== 4'h1) @(posedge ref_clk_i);
      word <= w[k % 3];
      while (idx === 4'h1) @(posedge ref_clk_i);
    end
    bus(0, `SMR_ADDR_CTRL, {7'h69, w[0][8]}, 8'hdf);
    bus(0, `SMR_ADDR_DATA, w[0][7:0], 8'hff);
    bus(0, `SMR_ADDR_CTRL, {7'h69, w[1][8]}, 8'hdf);
    bus(0, `SMR_ADDR_DATA, w[1][7:0], 8'hff);
    repeat (200) @(posedge ref_clk_i);
    bus(0, `SMR_ADDR_IRQ_STATUS, 8'h03, 8'hff);
    bus(1, `SMR_ADDR_CTRL, 8'hc0, 8'h00);
    bus(0, `SMR_ADDR_CTRL, 8'hc0, 8'hfe);
    tally_and_finish;
  end
endmodule // smr_sync_master_rx_tb
